// >>> dsw_consts.vh
// constants for the converter speed mode and write guard block
// assumes a 100 MHz peripheral clock and 32-bit AXI4-Lite access
`ifndef DSW_CONSTS_VH
`define DSW_CONSTS_VH

// ==========================================================
// register byte offsets
`define DSW_OFS_MODE    8'h04
`define DSW_OFS_CHEN    8'h10
`define DSW_OFS_CHDIS   8'h14
`define DSW_OFS_CHSR    8'h18
`define DSW_OFS_DATA    8'h20
`define DSW_OFS_ISR     8'h24
`define DSW_OFS_IMR     8'h28
`define DSW_OFS_ACR     8'h94
`define DSW_OFS_WPMR    8'hE4
`define DSW_OFS_WPSR    8'hE8

// ==========================================================
// field positions and widths
`define DSW_MODE_MAX_SPEED_SELECT   0
`define DSW_MODE_SEL    1
`define DSW_DATA_W      12
`define DSW_ACR_W       10
`define DSW_WPSR_SRC_LO 8
`define DSW_IRQ_EOC     0
`define DSW_IRQ_TXRDY   1

// ==========================================================
// reset values and timing
`define DSW_MODE_RST    2'h0
`define DSW_ACR_RST     10'h000
`define DSW_CONV_CYC    8'h19
`define DSW_RESP_OKAY   2'h0
`define DSW_RESP_SLVERR 2'h2

`endif

// >>> dsw_conv_timer.v
// internal conversion timer used in maximum speed mode
// assumes a one-cycle start pulse from the same clock domain
`timescale 1ns/1ps
`default_nettype none
`include "dsw_consts.vh"

module dsw_conv_timer (
  input  wire       i_clock,
  input  wire       i_rst,
  input  wire       i_start,
  output reg        o_done
);

  reg [7:0] cnt_q;

  // ==========================================================
  // down counter, done pulses one conversion time after start
  always @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      cnt_q  <= 8'h00;
      o_done <= 1'b0;
    end else begin
      o_done <= (cnt_q == 8'h01);
      if (i_start) begin
        cnt_q <= `DSW_CONV_CYC;
      end else if (cnt_q != 8'h00) begin
        cnt_q <= cnt_q - 8'h01;
      end
    end
  end

endmodule
`default_nettype wire

// >>> dsw_core_model.sv
// analog core stand-in: end-of-cycle after each start
// assumes one-cycle start pulses on the bench clock
`timescale 1ns/1ps
`default_nettype none
module dsw_core_model #(parameter int LAT = 25) (
  input  wire logic i_clock,
  input  wire logic i_start,
  input  wire logic i_mute,
  output logic      o_eoc
);
  // ==========================================
  // mute lets a scenario withhold the answer
  int cnt = 0;
  always @(posedge i_clock) begin
    if (i_start)
      cnt <= 1;
    else if (cnt != 0)
      cnt <= (cnt == LAT + 4) ? 0 : cnt + 1;
  end
  assign o_eoc = !i_mute && (cnt > LAT);
endmodule
`default_nettype wire

// >>> dsw_sva.sv
// port checks for dsw_top
// assumes bind onto every dsw_top instance
`timescale 1ns/1ps
`default_nettype none
module dsw_sva (
  input wire logic        i_clock,
  input wire logic        i_rst,
  input wire logic        i_awvalid,
  input wire logic        o_awready,
  input wire logic        i_wvalid,
  input wire logic        o_wready,
  input wire logic        o_bvalid,
  input wire logic        i_bready,
  input wire logic [1:0]  o_bresp,
  input wire logic        i_arvalid,
  input wire logic        o_arready,
  input wire logic        o_rvalid,
  input wire logic        i_rready,
  input wire logic [31:0] o_rdata,
  input wire logic        o_conv_start,
  input wire logic [11:0] o_conv_data,
  input wire logic [1:0]  o_chan_en,
  input wire logic [9:0]  o_analog_current
);
  // ==========================================
  // one clock domain only
  default clocking @(posedge i_clock); endclocking
  default disable iff (i_rst);
  sequence s_wtake;
    i_awvalid && o_awready && i_wvalid && o_wready;
  endsequence
  sequence s_quiet;
    !o_conv_start [*8];
  endsequence
  property p_wresp; s_wtake |-> ##2 o_bvalid; endproperty
  property p_rresp; i_arvalid && o_arready |=> o_rvalid; endproperty
  property p_bhold; o_bvalid && !i_bready |=> o_bvalid && $stable(o_bresp); endproperty
  property p_rhold; o_rvalid && !i_rready |=> o_rvalid && $stable(o_rdata); endproperty
  property p_space; o_conv_start |=> s_quiet; endproperty
  property p_data; $changed(o_conv_data) |-> o_conv_start; endproperty
  property p_chen; $changed(o_chan_en) |-> $rose(o_bvalid); endproperty
  property p_acr; $changed(o_analog_current) |-> $rose(o_bvalid); endproperty
  a_wresp: assert property (p_wresp) else $error("late write response");
  a_rresp: assert property (p_rresp) else $error("late read data");
  a_bhold: assert property (p_bhold) else $error("write response dropped");
  a_rhold: assert property (p_rhold) else $error("read data dropped");
  a_space: assert property (p_space) else $error("starts too close");
  a_data: assert property (p_data) else $error("data moved off start");
  a_chen: assert property (p_chen) else $error("enable moved off write");
  a_acr: assert property (p_acr) else $error("current moved off write");
endmodule
bind dsw_top dsw_sva u_sva (.i_clock, .i_rst, .i_awvalid, .o_awready, .i_wvalid,
  .o_wready, .o_bvalid, .i_bready, .o_bresp, .i_arvalid, .o_arready, .o_rvalid,
  .i_rready, .o_rdata, .o_conv_start, .o_conv_data, .o_chan_en, .o_analog_current);
`default_nettype wire

// >>> dsw_top.v
// converter control: speed mode engine, write guard, AXI4-Lite registers
// assumes the analog core raises a level end-of-cycle on i_conv_eoc
`timescale 1ns/1ps
`default_nettype none
`include "dsw_consts.vh"

module dsw_top (
  input  wire        i_clock,
  input  wire        i_rst,
  input  wire        i_awvalid,
  output reg         o_awready,
  input  wire [7:0]  i_awaddr,
  input  wire        i_wvalid,
  output reg         o_wready,
  input  wire [31:0] i_wdata,
  input  wire [3:0]  i_wstrb,
  output reg         o_bvalid,
  input  wire        i_bready,
  output reg  [1:0]  o_bresp,
  input  wire        i_arvalid,
  output reg         o_arready,
  input  wire [7:0]  i_araddr,
  output reg         o_rvalid,
  input  wire        i_rready,
  output reg  [31:0] o_rdata,
  output reg  [1:0]  o_rresp,
  input  wire        i_conv_eoc,
  output reg         o_conv_start,
  output reg  [11:0] o_conv_data,
  output reg         o_conv_chan,
  output reg  [1:0]  o_chan_en,
  output reg  [9:0]  o_analog_current,
  output reg         o_irq
);

  localparam ST_IDLE = 2'h0;
  localparam ST_WAIT = 2'h1;
  localparam ST_CNT  = 2'h2;

  // ==========================================================
  // decode helpers
  function is_protected;
    input [7:0] a;
    begin
      is_protected = (a == `DSW_OFS_MODE) || (a == `DSW_OFS_CHEN) ||
                     (a == `DSW_OFS_CHDIS) || (a == `DSW_OFS_ACR);
    end
  endfunction

  function is_mapped;
    input [7:0] a;
    begin
      is_mapped = is_protected(a) || (a == `DSW_OFS_CHSR) || (a == `DSW_OFS_DATA) ||
                  (a == `DSW_OFS_ISR) || (a == `DSW_OFS_IMR) ||
                  (a == `DSW_OFS_WPMR) || (a == `DSW_OFS_WPSR);
    end
  endfunction

  function [31:0] wmerge;
    input [31:0] old;
    input [31:0] nw;
    input [3:0]  strb;
    reg   [31:0] m;
    begin
      m      = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
      wmerge = (nw & m) | (old & ~m);
    end
  endfunction

  reg        aw_hold_q;
  reg        w_hold_q;
  reg [7:0]  awaddr_q;
  reg [31:0] wdata_q;
  reg [3:0]  wstrb_q;
  reg [1:0]  mode_q;
  reg        wp_en_q;
  reg        wp_flag_q;
  reg [7:0]  wp_src_q;
  reg [1:0]  isr_q;
  reg [1:0]  imr_q;
  reg [11:0] data_q;
  reg        data_full_q;
  reg [1:0]  state_q;
  reg        eoc_s1_q;
  reg        eoc_s2_q;
  reg        eoc_s3_q;
  wire       tmr_done;
  wire       eoc_rise;
  wire       do_write;
  wire       do_read;
  wire       wr_blocked;
  wire       start_now;
  wire [31:0] wd_mode;
  wire [31:0] wd_acr;

  assign do_write   = aw_hold_q & w_hold_q & ~o_bvalid;
  assign do_read    = i_arvalid & o_arready;
  assign wr_blocked = do_write & wp_en_q & is_protected(awaddr_q);
  assign eoc_rise   = eoc_s2_q & ~eoc_s3_q;
  assign start_now  = (state_q == ST_IDLE) & data_full_q & o_chan_en[mode_q[`DSW_MODE_SEL]];
  assign wd_mode    = wmerge({30'h0, mode_q}, wdata_q, wstrb_q);
  assign wd_acr     = wmerge({22'h0, o_analog_current}, wdata_q, wstrb_q);

  // ==========================================================
  // end-of-cycle synchroniser, the third stage only feeds the edge detect
  always @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      eoc_s1_q <= 1'b0;
      eoc_s2_q <= 1'b0;
      eoc_s3_q <= 1'b0;
    end else begin
      eoc_s1_q <= i_conv_eoc;
      eoc_s2_q <= eoc_s1_q;
      eoc_s3_q <= eoc_s2_q;
    end
  end

  // ==========================================================
  // write channel: address and data taken in either order
  always @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      aw_hold_q <= 1'b0;
      w_hold_q  <= 1'b0;
      awaddr_q  <= 8'h00;
      wdata_q   <= 32'h0000_0000;
      wstrb_q   <= 4'h0;
      o_awready <= 1'b0;
      o_wready  <= 1'b0;
      o_bvalid  <= 1'b0;
      o_bresp   <= `DSW_RESP_OKAY;
    end else begin
      o_awready <= ~aw_hold_q & ~(i_awvalid & o_awready) & ~do_write & ~o_bvalid;
      o_wready  <= ~w_hold_q & ~(i_wvalid & o_wready) & ~do_write & ~o_bvalid;
      if (i_awvalid & o_awready) begin
        aw_hold_q <= 1'b1;
        awaddr_q  <= i_awaddr;
      end
      if (i_wvalid & o_wready) begin
        w_hold_q <= 1'b1;
        wdata_q  <= i_wdata;
        wstrb_q  <= i_wstrb;
      end
      if (do_write) begin
        aw_hold_q <= 1'b0;
        w_hold_q  <= 1'b0;
        o_bvalid  <= 1'b1;
        o_bresp   <= is_mapped(awaddr_q) ? `DSW_RESP_OKAY : `DSW_RESP_SLVERR;
      end else if (o_bvalid & i_bready) begin
        o_bvalid <= 1'b0;
      end
    end
  end

  // ==========================================================
  // configuration registers; the guard blocks MODE, CHEN, CHDIS and ACR writes
  always @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      mode_q           <= `DSW_MODE_RST;
      o_chan_en        <= 2'h0;
      o_analog_current <= `DSW_ACR_RST;
      wp_en_q          <= 1'b0;
      imr_q            <= 2'h0;
    end else if (do_write & ~wr_blocked) begin
      case (awaddr_q)
        `DSW_OFS_MODE:  mode_q           <= wd_mode[1:0];
        `DSW_OFS_CHEN:  o_chan_en        <= o_chan_en | wdata_q[1:0];
        `DSW_OFS_CHDIS: o_chan_en        <= o_chan_en & ~wdata_q[1:0];
        `DSW_OFS_ACR:   o_analog_current <= wd_acr[9:0];
        `DSW_OFS_IMR:   imr_q            <= wdata_q[1:0];
        `DSW_OFS_WPMR:  wp_en_q          <= wdata_q[0];
        default:        imr_q            <= imr_q;
      endcase
    end
  end

  // ==========================================================
  // violation capture; a new violation beats the read clear
  always @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      wp_flag_q <= 1'b0;
      wp_src_q  <= 8'h00;
    end else if (wr_blocked) begin
      wp_flag_q <= 1'b1;
      wp_src_q  <= awaddr_q;
    end else if (do_read & (i_araddr == `DSW_OFS_WPSR)) begin
      wp_flag_q <= 1'b0;
    end
  end

  // ==========================================================
  // read channel, answer one cycle after address is taken
  always @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      o_arready <= 1'b0;
      o_rvalid  <= 1'b0;
      o_rdata   <= 32'h0000_0000;
      o_rresp   <= `DSW_RESP_OKAY;
    end else begin
      o_arready <= ~do_read & ~o_rvalid;
      if (do_read) begin
        o_rvalid <= 1'b1;
        o_rresp  <= is_mapped(i_araddr) ? `DSW_RESP_OKAY : `DSW_RESP_SLVERR;
        case (i_araddr)
          `DSW_OFS_MODE: o_rdata <= {30'h0, mode_q};
          `DSW_OFS_CHSR: o_rdata <= {30'h0, o_chan_en};
          `DSW_OFS_ISR:  o_rdata <= {30'h0, isr_q};
          `DSW_OFS_IMR:  o_rdata <= {30'h0, imr_q};
          `DSW_OFS_ACR:  o_rdata <= {22'h0, o_analog_current};
          `DSW_OFS_WPMR: o_rdata <= {31'h0, wp_en_q};
          `DSW_OFS_WPSR: o_rdata <= {16'h0, wp_src_q, 7'h00, wp_flag_q};
          default:       o_rdata <= 32'h0000_0000;
        endcase
      end else if (o_rvalid & i_rready) begin
        o_rvalid <= 1'b0;
      end
    end
  end

  // ==========================================================
  // data holding register, one word deep
  always @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      data_q      <= 12'h000;
      data_full_q <= 1'b0;
    end else if (do_write & (awaddr_q == `DSW_OFS_DATA)) begin
      // writer paces refresh; a late word overwrites the held one
      data_q      <= wdata_q[11:0];
      data_full_q <= 1'b1;
    end else if (start_now) begin
      data_full_q <= 1'b0;
    end
  end

  dsw_conv_timer u_timer (
    .i_clock (i_clock),
    .i_rst   (i_rst),
    .i_start (o_conv_start),
    .o_done  (tmr_done)
  );

  // ==========================================================
  // conversion engine
  always @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      state_q      <= ST_IDLE;
      o_conv_start <= 1'b0;
      o_conv_data  <= 12'h000;
      o_conv_chan  <= 1'b0;
    end else begin
      o_conv_start <= start_now;
      case (state_q)
        ST_IDLE: begin
          if (start_now) begin
            o_conv_data <= data_q;
            o_conv_chan <= mode_q[`DSW_MODE_SEL];
            state_q     <= mode_q[`DSW_MODE_MAX_SPEED_SELECT] ? ST_CNT : ST_WAIT;
          end
        end
        ST_WAIT: begin
          if (eoc_rise) begin
            state_q <= ST_IDLE;
          end
        end
        ST_CNT: begin
          if (tmr_done) begin
            state_q <= ST_IDLE;
          end
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  // ==========================================================
  // sticky events, read of status clears, set beats clear
  always @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      isr_q <= 2'h0;
      o_irq <= 1'b0;
    end else begin
      // done follows synced end-of-cycle in every mode
      isr_q[`DSW_IRQ_EOC]   <= eoc_rise |
        (isr_q[`DSW_IRQ_EOC] & ~(do_read & (i_araddr == `DSW_OFS_ISR)));
      isr_q[`DSW_IRQ_TXRDY] <= start_now |
        (isr_q[`DSW_IRQ_TXRDY] & ~(do_read & (i_araddr == `DSW_OFS_ISR)));
      o_irq <= |(isr_q & imr_q);
    end
  end

endmodule
`default_nettype wire

// >>> dsw_top_tb.sv
// self-checking bench for dsw_top
// assumes the core model answers each start while mute is low
`timescale 1ns/1ps
`default_nettype none
module dsw_top_tb;
  logic        i_clock = 0, i_rst = 1, mute = 0;
  logic        i_awvalid = 0, i_wvalid = 0, i_bready = 0, i_arvalid = 0, i_rready = 0;
  logic [7:0]  i_awaddr = 0, i_araddr = 0, pa[4] = '{8'h04, 8'h10, 8'h14, 8'h94};
  logic [31:0] i_wdata = 0, rs = 32'h31EE;
  logic [3:0]  i_wstrb = 4'hF;
  wire         i_conv_eoc, o_awready, o_wready, o_bvalid, o_arready, o_rvalid;
  wire         o_conv_start, o_conv_chan, o_irq;
  wire  [1:0]  o_bresp, o_rresp, o_chan_en;
  wire  [31:0] o_rdata;
  wire  [11:0] o_conv_data;
  wire  [9:0]  o_analog_current;
  logic [33:0] qe[$], qm[$], m;
  logic [11:0] qc[$];
  logic [1:0]  qb[$];
  int          n_errors = 0, n_tests = 0, n_st = 0;
  time         tp = 0, tl = 0, n_t;
  always #5 i_clock = ~i_clock;
  dsw_top u_dut (.i_clock, .i_rst, .i_awvalid, .o_awready, .i_awaddr, .i_wvalid, .o_wready,
    .i_wdata, .i_wstrb, .o_bvalid, .i_bready, .o_bresp, .i_arvalid, .o_arready, .i_araddr,
    .o_rvalid, .i_rready, .o_rdata, .o_rresp, .i_conv_eoc, .o_conv_start, .o_conv_data,
    .o_conv_chan, .o_chan_en, .o_analog_current, .o_irq);
  // latency lines the raw end-of-cycle up with the internal timer's done pulse
  dsw_core_model #(.LAT(25)) u_core (.i_clock, .i_start(o_conv_start), .i_mute(mute),
    .o_eoc(i_conv_eoc));
  // ==========================================
  // helpers
  function automatic logic [31:0] xs(input logic [31:0] x);
    x = x ^ (x << 13);
    x = x ^ (x >> 17);
    x = x ^ (x << 5);
    return x;
  endfunction
  task automatic chk(input logic [33:0] g, input logic [33:0] e);
    n_tests++;
    if (g !== e) begin
      n_errors++;
      $display("[FAIL] %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic end_sim;
    $display("tests %0d errors %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  // write: address and data offered together
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r = 2'h0);
    qb.push_back(r);
    i_awvalid <= 1;
    i_awaddr <= a;
    i_wvalid <= 1;
    i_wdata <= d;
    i_bready <= 1;
    fork
      begin do @(posedge i_clock); while (!o_awready); i_awvalid <= 0; end
      begin do @(posedge i_clock); while (!o_wready); i_wvalid <= 0; end
    join
    do @(posedge i_clock); while (!o_bvalid);
    i_bready <= 0;
    // one idle edge so a following call never re-drives bready in this step
    @(posedge i_clock);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] k = '1);
    qe.push_back({2'h0, e});
    qm.push_back({2'h3, k});
    i_arvalid <= 1;
    i_araddr <= a;
    i_rready <= 1;
    do @(posedge i_clock); while (!o_arready);
    i_arvalid <= 0;
    do @(posedge i_clock); while (!o_rvalid);
    i_rready <= 0;
    // one idle edge so a following call never re-drives rready in this step
    @(posedge i_clock);
  endtask
  // one conversion word, returns after its start
  task automatic cv;
    int k;
    k = n_st;
    rs = xs(rs);
    qc.push_back(rs[11:0]);
    wr(8'h20, {20'h0, rs[11:0]});
    do @(posedge i_clock); while (n_st == k);
  endtask
  // ==========================================
  // result watcher: oldest note against each answer
  always @(posedge i_clock) begin
    if (o_rvalid && i_rready) begin
      m = qm.pop_front();
      chk({o_rresp, o_rdata} & m, qe.pop_front() & m);
    end
    if (o_bvalid && i_bready)
      chk(o_bresp, qb.pop_front());
    if (o_conv_start) begin
      n_st <= n_st + 1;
      tp <= tl;
      tl <= $time;
      if (qc.size() == 0)
        chk(34'h1, 34'h0);
      else
        chk(o_conv_data, qc.pop_front());
    end
  end
  // ==========================================
  // main sequence
  initial begin
    repeat (20) @(posedge i_clock);
    i_rst <= 0;
    repeat (2) @(posedge i_clock);
    rd(8'h04, 32'h0);
    rd(8'h94, 32'h0);
    wr(8'h08, 32'h1, 2'h2);
    wr(8'h28, 32'h1);
    wr(8'h10, 32'h1);
    repeat (2) cv();
    n_t = tl - tp;
    chk(o_conv_chan, 1'b0);
    repeat (40) @(posedge i_clock);
    chk(o_irq, 1);
    rd(8'h24, 32'h1, 32'h1);
    repeat (3) @(posedge i_clock);
    chk(o_irq, 0);
    wr(8'h04, 32'h1);
    mute <= 1;
    repeat (2) cv();
    // max speed spacing is exactly two periods (20 ns) shorter
    chk(tl - tp + 20, n_t);
    repeat (40) @(posedge i_clock);
    // no end-of-cycle came, so the done flag must still be clear
    chk(o_irq, 0);
    mute <= 0;
    // normal mode on channel 1, then back to channel 0 only
    wr(8'h10, 32'h2);
    wr(8'h04, 32'h2);
    wr(8'h28, 32'h0);
    cv();
    chk(o_conv_chan, 1'b1);
    repeat (40) @(posedge i_clock);
    chk(o_irq, 0);
    rd(8'h24, 32'h1, 32'h1);
    wr(8'h14, 32'h2);
    wr(8'h04, 32'h0);
    wr(8'h94, 32'h155);
    wr(8'hE4, 32'h1);
    // all-ones data would move every guarded register if the guard leaked
    foreach (pa[i]) begin
      wr(pa[i], 32'h3FF);
      chk(o_chan_en, 2'h1);
      rd(8'hE8, {16'h0, pa[i], 8'h01}, 32'hFF01);
    end
    rd(8'h94, 32'h155);
    rd(8'h04, 32'h0);
    rd(8'hE8, 32'h0, 32'h1);
    wr(8'hE4, 32'h0);
    wr(8'h94, 32'h2AA);
    rd(8'h94, 32'h2AA);
    end_sim();
  end
  // hang guard: the sequence needs under 2000 cycles
  initial begin
    #50000;
    n_errors++;
    end_sim();
  end
endmodule
`default_nettype wire
